/* rtl/bsx_pkg.sv */
package bsx_pkg;

   // ------------------------------------------------------------
   // Status flag bit positions
   // ------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ------------------------------------------------------------
   // Reset values and timing counts
   // ------------------------------------------------------------
   localparam logic [7:0]  FLAGS_RESET     = 8'h00;
   localparam logic [15:0] PC_RESET        = 16'h0000;
   localparam logic [1:0]  CYC_ONE         = 2'h1;
   localparam logic [1:0]  CYC_IO_BIT      = 2'h2;
   localparam logic [1:0]  CYC_BR_TAKEN    = 2'h2;
   localparam logic [1:0]  CYC_SKIP_ONE    = 2'h2;
   localparam logic [1:0]  CYC_SKIP_TWO    = 2'h3;
   localparam logic [15:0] PC_STEP_ONE     = 16'h0001;
   localparam logic [15:0] PC_STEP_SKIP1   = 16'h0002;
   localparam logic [15:0] PC_STEP_SKIP2   = 16'h0003;

   // ------------------------------------------------------------
   // Operations of this slice
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE,
      OP_CMP_CARRY,
      OP_CMP_IMM,
      OP_SKIP_REG_CLR,
      OP_SKIP_REG_SET,
      OP_SKIP_IO_CLR,
      OP_SKIP_IO_SET,
      OP_BRANCH_SET,
      OP_BRANCH_CLR,
      OP_BRANCH_GE,
      OP_BRANCH_LT,
      OP_IO_SET,
      OP_IO_CLR,
      OP_LSL,
      OP_LSR,
      OP_ROL,
      OP_ROR,
      OP_ASR,
      OP_BIT_TO_T,
      OP_T_TO_BIT
   } bsx_op_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT
   } bsx_state_e;

endpackage : bsx_pkg

/* rtl/bsx_if.sv */
`timescale 1ns/1ns
interface bsx_if;
   import bsx_pkg::*;
   logic [7:0] opA;
   logic [7:0] opB;
   logic       carryIn;
   logic [7:0] result;
   logic [7:0] flagsIn;
   logic [7:0] flagsOut;
   logic       writesReg;
   bsx_op_e    op;

   modport unit (input opA, input opB, input carryIn, input op, input flagsIn,
                 output result, output flagsOut, output writesReg);
   modport core (output opA, output opB, output carryIn, output op, output flagsIn,
                 input result, input flagsOut, input writesReg);
endinterface : bsx_if

/* rtl/bsx_alu.sv */
`timescale 1ns/1ns
module bsx_alu
   import bsx_pkg::*;
(
   // Operand side
   bsx_if.unit alu
);

   logic [7:0] r;
   logic [7:0] f;
   logic       c;
   logic       w;
   logic [8:0] diff;
   logic [4:0] lowDiff;

   always_comb begin
      r       = alu.opA;
      f       = alu.flagsIn;
      c       = alu.flagsIn[FLAG_C];
      w       = 1'b0;
      diff    = {1'b0, alu.opA} - {1'b0, alu.opB} - {8'h00, alu.carryIn};
      lowDiff = {1'b0, alu.opA[3:0]} - {1'b0, alu.opB[3:0]} - {4'h0, alu.carryIn};
      case (alu.op)
         OP_CMP_CARRY, OP_CMP_IMM: begin
            // Difference discarded; flags only
            f[FLAG_C] = diff[8];
            f[FLAG_H] = lowDiff[4];
            f[FLAG_N] = diff[7];
            f[FLAG_V] = (alu.opA[7] & ~alu.opB[7] & ~diff[7]) | (~alu.opA[7] & alu.opB[7] & diff[7]);
            // Compare with carry clears Z unless result is zero
            if (alu.op == OP_CMP_CARRY) begin
               f[FLAG_Z] = (diff[7:0] == 8'h00) & alu.flagsIn[FLAG_Z];
            end else begin
               f[FLAG_Z] = (diff[7:0] == 8'h00);
            end
            f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
         end
         OP_LSL, OP_ROL: begin
            r = {alu.opA[6:0], (alu.op == OP_ROL) ? alu.flagsIn[FLAG_C] : 1'b0};
            c = alu.opA[7];
            w = 1'b1;
         end
         OP_LSR, OP_ROR: begin
            r = {(alu.op == OP_ROR) ? alu.flagsIn[FLAG_C] : 1'b0, alu.opA[7:1]};
            c = alu.opA[0];
            w = 1'b1;
         end
         OP_ASR: begin
            r = {alu.opA[7], alu.opA[7:1]};
            c = alu.opA[0];
            w = 1'b1;
         end
         default: begin
            r = alu.opA;
         end
      endcase
      if (w) begin
         f[FLAG_C] = c;
         f[FLAG_Z] = (r == 8'h00);
         f[FLAG_N] = r[7];
         f[FLAG_V] = r[7] ^ c;
         f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
      end
   end

   assign alu.result    = r;
   assign alu.flagsOut  = f;
   assign alu.writesReg = w;

endmodule : bsx_alu

/* rtl/bsx_exec_unit.sv */
`timescale 1ns/1ns
// Contract
// - Compares update Z,N,V,C,H in one clock
// - Register bit skip advances PC 2 or 3
// - I/O bit skip on bit zero/one
// - Flag branch target PC plus k plus one
// - Zero, carry, negative branches on condition
// - Unsigned branches test carry clear or set
// - Signed branches test N xor V
// - Half-carry and T flag branches
// - Overflow branches alter no flag
// - Interrupt-enable branches use same target
// - I/O bit set/clear, two clocks
// - Left shift and rotate through carry
// - Right shift and rotate through carry
// - Arithmetic right shift keeps sign bit
// - Bit store copies register bit to T
// - Bit load writes T into register bit
module bsx_exec_unit
   import bsx_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Instruction issue
   input  wire logic        issueValid,
   input  wire bsx_op_e     issueOp,
   input  wire logic [15:0] issuePc,
   input  wire logic [7:0]  regOperandA,
   input  wire logic [7:0]  regOperandB,
   input  wire logic [2:0]  bitSel,
   input  wire logic signed [6:0] branchOffset,
   input  wire logic        nextIsTwoWord,
   // I/O space
   input  wire logic [7:0]  ioReadData,
   input  wire logic [4:0]  ioAddr,
   // Results
   output logic             busy,
   output logic             done,
   output logic [15:0]      pcOut,
   output logic             pcLoad,
   output logic [7:0]       regWriteData,
   output logic             regWrite,
   output logic [7:0]       ioWriteData,
   output logic [4:0]       ioWriteAddr,
   output logic             ioWrite,
   output logic [7:0]       status_flags_register
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      bsx_state_e  state;
      logic [1:0]  cyclesLeft;
      logic [7:0]  flags;
      logic [15:0] pc;
      logic        pcLoad;
      logic        done;
      logic [7:0]  regData;
      logic        regWrite;
      logic [7:0]  ioData;
      logic [4:0]  ioAddr;
      logic        ioWrite;
   } bsx_state_s;

   bsx_state_s st_reg;
   bsx_state_s st_next;

   bsx_if aluBus ();

   bsx_alu u_alu (
      .alu (aluBus.unit)
   );

   // ------------------------------------------------------------
   // Shift and compare datapath
   // ------------------------------------------------------------
   assign aluBus.opA     = regOperandA;
   assign aluBus.opB     = regOperandB;
   assign aluBus.carryIn = (issueOp == OP_CMP_CARRY) ? st_reg.flags[FLAG_C] : 1'b0;
   assign aluBus.op      = issueOp;
   assign aluBus.flagsIn = st_reg.flags;

   logic       testBit;
   logic       condMet;
   logic [15:0] branchTarget;
   logic [2:0] flagIdx;

   always_comb begin
      flagIdx      = bitSel;
      testBit      = 1'b0;
      condMet      = 1'b0;
      branchTarget = issuePc + {{9{branchOffset[6]}}, branchOffset} + PC_STEP_ONE;
      case (issueOp)
         OP_SKIP_REG_CLR: begin
            testBit = regOperandA[bitSel];
            condMet = ~testBit;
         end
         OP_SKIP_REG_SET: begin
            testBit = regOperandA[bitSel];
            condMet = testBit;
         end
         OP_SKIP_IO_CLR: begin
            testBit = ioReadData[bitSel];
            condMet = ~testBit;
         end
         OP_SKIP_IO_SET: begin
            testBit = ioReadData[bitSel];
            condMet = testBit;
         end
         OP_BRANCH_SET: begin
            // Z, C, N, H, T, V, I by flag index
            condMet = st_reg.flags[flagIdx];
         end
         OP_BRANCH_CLR: begin
            condMet = ~st_reg.flags[flagIdx];
         end
         OP_BRANCH_GE: begin
            condMet = ~(st_reg.flags[FLAG_N] ^ st_reg.flags[FLAG_V]);
         end
         OP_BRANCH_LT: begin
            condMet = st_reg.flags[FLAG_N] ^ st_reg.flags[FLAG_V];
         end
         default: begin
            condMet = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   always_comb begin
      st_next          = st_reg;
      st_next.pcLoad   = 1'b0;
      st_next.done     = 1'b0;
      st_next.regWrite = 1'b0;
      st_next.ioWrite  = 1'b0;
      case (st_reg.state)
         ST_IDLE: begin
            if (issueValid) begin
               st_next.pc         = issuePc + PC_STEP_ONE;
               st_next.cyclesLeft = 2'h0;
               case (issueOp)
                  OP_CMP_CARRY, OP_CMP_IMM: begin
                     st_next.flags = aluBus.flagsOut;
                  end
                  OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: begin
                     st_next.flags    = aluBus.flagsOut;
                     st_next.regData  = aluBus.result;
                     st_next.regWrite = aluBus.writesReg;
                  end
                  OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
                     if (condMet) begin
                        // Skip length tracks the skipped word count
                        st_next.pc = issuePc + (nextIsTwoWord ? PC_STEP_SKIP2 : PC_STEP_SKIP1);
                        st_next.cyclesLeft = (nextIsTwoWord ? CYC_SKIP_TWO : CYC_SKIP_ONE) - CYC_ONE;
                     end
                  end
                  OP_BRANCH_SET, OP_BRANCH_CLR, OP_BRANCH_GE, OP_BRANCH_LT: begin
                     if (condMet) begin
                        st_next.pc         = branchTarget;
                        st_next.cyclesLeft = CYC_BR_TAKEN - CYC_ONE;
                     end
                  end
                  OP_IO_SET, OP_IO_CLR: begin
                     st_next.ioData = ioReadData;
                     st_next.ioData[bitSel] = (issueOp == OP_IO_SET);
                     st_next.ioAddr     = ioAddr;
                     st_next.ioWrite    = 1'b1;
                     st_next.cyclesLeft = CYC_IO_BIT - CYC_ONE;
                  end
                  OP_BIT_TO_T: begin
                     st_next.flags[FLAG_T] = regOperandA[bitSel];
                  end
                  OP_T_TO_BIT: begin
                     st_next.regData         = regOperandA;
                     st_next.regData[bitSel] = st_reg.flags[FLAG_T];
                     st_next.regWrite        = 1'b1;
                  end
                  default: begin
                     st_next.pc = st_reg.pc;
                  end
               endcase
               if (st_next.cyclesLeft == 2'h0) begin
                  st_next.done   = (issueOp != OP_NONE);
                  st_next.pcLoad = (issueOp != OP_NONE);
               end else begin
                  st_next.state = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            st_next.cyclesLeft = st_reg.cyclesLeft - CYC_ONE;
            if (st_reg.cyclesLeft == CYC_ONE) begin
               st_next.state  = ST_IDLE;
               st_next.done   = 1'b1;
               st_next.pcLoad = 1'b1;
            end
         end
         default: begin
            st_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{state: ST_IDLE, cyclesLeft: 2'h0, flags: FLAGS_RESET, pc: PC_RESET,
                     pcLoad: 1'b0, done: 1'b0, regData: 8'h00, regWrite: 1'b0,
                     ioData: 8'h00, ioAddr: 5'h00, ioWrite: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign busy                  = (st_reg.state == ST_WAIT);
   assign done                  = st_reg.done;
   assign pcOut                 = st_reg.pc;
   assign pcLoad                = st_reg.pcLoad;
   assign regWriteData          = st_reg.regData;
   assign regWrite              = st_reg.regWrite;
   assign ioWriteData           = st_reg.ioData;
   assign ioWriteAddr           = st_reg.ioAddr;
   assign ioWrite               = st_reg.ioWrite;
   assign status_flags_register = st_reg.flags;

endmodule : bsx_exec_unit

/* verif/bsx_exec_unit_monitor.sv */
`timescale 1ns/1ns
module bsx_exec_unit_monitor
   import bsx_pkg::*;
(
   // Unit inputs
   input wire logic              core_clk,
   input wire logic              rst_n,
   input wire logic              issueValid,
   input wire bsx_op_e           issueOp,
   input wire logic [15:0]       issuePc,
   input wire logic [7:0]        regOperandA,
   input wire logic [2:0]        bitSel,
   input wire logic signed [6:0] branchOffset,
   input wire logic              nextIsTwoWord,
   input wire logic [7:0]        ioReadData,
   // Unit outputs
   input wire logic              busy,
   input wire logic              done,
   input wire logic [15:0]       pcOut,
   input wire logic              pcLoad,
   input wire logic              regWrite,
   input wire logic [7:0]        regWriteData,
   input wire logic              ioWrite,
   input wire logic [7:0]        ioWriteData,
   input wire logic [7:0]        status_flags_register
);
   // ------------
   // Helpers
   // ------------
   logic        take;
   logic        flagHit;
   logic        selBit;
   logic [8:0]  lslFull;
   logic [7:0]  ioSet;
   logic [15:0] target;
   assign take    = issueValid && !busy;
   assign flagHit = status_flags_register[bitSel];
   assign selBit  = regOperandA[bitSel];
   assign lslFull = {regOperandA, 1'b0};
   assign ioSet   = ioReadData | (8'h01 << bitSel);
   assign target  = issuePc + 16'(branchOffset) + 16'h0001;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence lateDone;
      !done ##1 done;
   endsequence
   // ------------
   // Properties
   // ------------
   a_one_clk_ops: assert property (take && issueOp inside {OP_CMP_CARRY, OP_CMP_IMM, OP_LSL, OP_LSR, OP_ROL,
      OP_ROR, OP_ASR, OP_BIT_TO_T, OP_T_TO_BIT} |=> done && !busy) else $error("single clock op late");
   a_io_two_clk: assert property (take && issueOp inside {OP_IO_SET, OP_IO_CLR} |=> ioWrite
      && status_flags_register == $past(status_flags_register) ##0 lateDone) else $error("io bit op timing");
   a_io_set_bit: assert property (take && issueOp == OP_IO_SET |=> ioWriteData == $past(ioSet))
      else $error("io set data wrong");
   a_br_fallthrough: assert property (take && issueOp == OP_BRANCH_SET && !flagHit
      |=> done && pcLoad && pcOut == $past(issuePc) + 16'h0001) else $error("branch fall through wrong");
   a_br_taken: assert property (take && issueOp == OP_BRANCH_CLR && !flagHit
      |=> lateDone ##0 pcOut == $past(target, 2)) else $error("taken branch wrong");
   a_signed_lt: assert property (take && issueOp == OP_BRANCH_LT
      && (status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V]) |=> lateDone) else $error("signed lt");
   a_skip_long: assert property (take && issueOp == OP_SKIP_REG_SET && selBit && nextIsTwoWord
      |=> !done [*2] ##1 done && pcOut == $past(issuePc, 3) + 16'h0003) else $error("long skip wrong");
   a_skip_io_none: assert property (take && issueOp == OP_SKIP_IO_SET && !ioReadData[bitSel]
      |=> done && pcOut == $past(issuePc) + 16'h0001) else $error("io skip not taken wrong");
   a_lsl_shift: assert property (take && issueOp == OP_LSL
      |=> regWrite && {status_flags_register[FLAG_C], regWriteData} == $past(lslFull)) else $error("lsl wrong");
   a_bst_tflag: assert property (take && issueOp == OP_BIT_TO_T |=> status_flags_register[FLAG_T] ==
      $past(selBit) && (status_flags_register & 8'hBF) == ($past(status_flags_register) & 8'hBF)) else $error("bst");
endmodule : bsx_exec_unit_monitor

bind bsx_exec_unit bsx_exec_unit_monitor i_bsx_exec_unit_monitor (.core_clk, .rst_n, .issueValid, .issueOp,
   .issuePc, .regOperandA, .bitSel, .branchOffset, .nextIsTwoWord, .ioReadData, .busy, .done, .pcOut, .pcLoad,
   .regWrite, .regWriteData, .ioWrite, .ioWriteData, .status_flags_register);

/* verif/tb.sv */
`timescale 1ns/1ns
module tb;
   import bsx_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, issueValid = 1'b0, nextIsTwoWord = 1'b0;
   logic [15:0] issuePc = 16'h0000;
   logic [7:0] regOperandA = 8'h00, regOperandB = 8'h00, ioReadData = 8'h00, rV, ioV;
   logic [6:0] branchOffset = 7'h00;
   logic [4:0] ioAddr = 5'h13;
   logic [2:0] bitSel = 3'h0;
   bsx_op_e issueOp = OP_NONE;
   wire logic busy, done, pcLoad, regWrite, ioWrite;
   wire logic [15:0] pcOut;
   wire logic [7:0] regWriteData, ioWriteData, status_flags_register;
   wire logic [4:0] ioWriteAddr;
   int n_fail = 0, comparisons = 0, cyc;
   bsx_op_e opT[14] = '{OP_CMP_IMM, OP_CMP_CARRY, OP_CMP_CARRY, OP_CMP_IMM, OP_BIT_TO_T, OP_LSL, OP_ROL, OP_ROR,
                        OP_LSR, OP_ASR, OP_ROR, OP_T_TO_BIT, OP_BIT_TO_T, OP_T_TO_BIT};
   // Operand A, operand B, bit select, result, flags after
   logic [39:0] rowT[14] = '{40'h102000EE15, 40'h050500EE35, 40'h050400EE00, 40'h800100EE38, 40'h080003EE78,
      40'h8100000279, 40'h400000816C, 40'h010000007B, 40'h0200000160, 40'h850000C275, 40'h000000806C,
      40'h000006406C, 40'h000006EE2C, 40'hFF0000FE2C};
   always #5 core_clk = ~core_clk;
   bsx_exec_unit i_bsx_exec_unit (.core_clk, .rst_n, .issueValid, .issueOp, .issuePc, .regOperandA, .regOperandB,
      .bitSel, .branchOffset, .nextIsTwoWord, .ioReadData, .ioAddr, .busy, .done, .pcOut, .pcLoad, .regWriteData,
      .regWrite, .ioWriteData, .ioWriteAddr, .ioWrite, .status_flags_register);
   // ------------
   // Tasks
   // ------------
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic results();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic run(bsx_op_e op, logic [7:0] a, b, logic [2:0] s, logic [6:0] k, logic tw, logic [7:0] io);
      @(posedge core_clk);
      issueValid <= 1'b1;
      issueOp <= op;
      regOperandA <= a;
      regOperandB <= b;
      bitSel <= s;
      branchOffset <= k;
      nextIsTwoWord <= tw;
      ioReadData <= io;
      issuePc <= issuePc + 16'h0040;
      rV = 8'hEE;
      ioV = 8'hEE;
      cyc = 0;
      for (int i = 1; i <= 4 && cyc == 0; i++) begin
         @(posedge core_clk);
         issueValid <= 1'b0;
         #1;
         if (regWrite === 1'b1)
            rV = regWriteData;
         if (ioWrite === 1'b1)
            ioV = ioWriteData;
         if (done === 1'b1)
            cyc = i;
      end
      if (cyc == 0) begin
         chk("done seen", 16'h0001, 16'h0000);
         results();
      end
      chk("pcLoad", 16'h0001, pcLoad);
   endtask : run
   task automatic br(logic [7:0] f);
      logic tk;
      for (int j = 0; j < 18; j++) begin
         tk = j < 8 ? f[j] : j < 16 ? !f[j-8] : (j == 16) == !(f[FLAG_N] ^ f[FLAG_V]);
         run(j < 8 ? OP_BRANCH_SET : j < 16 ? OP_BRANCH_CLR : j == 16 ? OP_BRANCH_GE : OP_BRANCH_LT,
             8'h00, 8'h00, 3'(j), 7'h7D, 1'b0, 8'h00);
         chk("branch cycles", tk ? 16'h0002 : 16'h0001, 16'(cyc));
         chk("branch pc", tk ? issuePc - 16'h0002 : issuePc + 16'h0001, pcOut);
      end
      chk("branch flags", f, status_flags_register);
   endtask : br
   // ------------
   // Sequence
   // ------------
   initial begin
      logic [39:0] row;
      logic [7:0] v;
      int n;
      repeat (3) @(posedge core_clk);
      chk("reset flags", FLAGS_RESET, status_flags_register);
      chk("reset pc", PC_RESET, pcOut);
      rst_n <= 1'b1;
      $display("Test reset done");
      for (int r = 0; r < 14; r++) begin
         row = rowT[r];
         run(opT[r], row[39:32], row[31:24], row[18:16], 7'h00, 1'b0, 8'h00);
         chk("reg data", row[15:8], rV);
         chk("flags", row[7:0], status_flags_register);
         chk("op cycles", 16'h0001, 16'(cyc));
         br(row[7:0]);
      end
      $display("Test flag ops and branches done");
      for (int j = 0; j < 2; j++) begin
         run(j ? OP_IO_CLR : OP_IO_SET, 8'h00, 8'h00, j ? 3'h7 : 3'h3, 7'h00, 1'b0, 8'h81);
         chk("io data", j ? 8'h01 : 8'h89, ioV);
         chk("io cycles", 16'h0002, 16'(cyc));
         chk("io addr", ioAddr, ioWriteAddr);
         chk("io flags", 8'h2C, status_flags_register);
      end
      $display("Test io bit ops done");
      for (int j = 0; j < 16; j++) begin
         v = j[1] ? 8'h20 : 8'hDF;
         n = (j[2] == j[1]) ? (j[0] ? 3 : 2) : 1;
         run(bsx_op_e'(int'(OP_SKIP_REG_CLR) + j / 4), j[3] ? ~v : v, 8'h00, 3'h5, 7'h00, j[0],
             j[3] ? v : ~v);
         chk("skip cycles", 16'(n), 16'(cyc));
         chk("skip pc", issuePc + 16'(n), pcOut);
      end
      $display("Test skips done");
      results();
   end
endmodule : tb
